// file: verilog/hbr_recovery.sv
// i2c bus-hang recovery engine: watches master resets, sda and sck,
// and frees a slave stuck on sda with nine open-drain clocks, plus a stop in multi master mode
// assumes external pull-ups on sda and sck; pins are split in/out/oe_n
//
// Overview of operation
// - reset indication of each master is an input; sda and sck observed and driven
// - pins only ever pulled low or released, never driven high
// - on a master entering reset, sda is sampled for a stuck low
// - single master: sda low during reset means a hung bus
// - a hang gets nine sck pulses, sck left released high
// - each pulse keeps the minimum low and high phase times
// - after the pulses sda is sampled again to confirm release
// - multi master: any master in reset starts hang evaluation
// - sda high during a master reset means no hang, nothing done
// - sda low with sck toggling is another master's traffic, left alone
// - sda low and sck high beyond the timeout declares a hang
// - timeout is four times the slowest master's longest sck high
// - sda and sck sampled many times per bus clock period
// - multi master: a stop condition follows the nine pulses
// - a start is sda falling while sck is high
// - a stop is sda rising while sck is high, releasing the bus
`timescale 1ns/1ps
`include "hbr_params.svh"
module hbr_recovery
  import hbr_pkg::*;
#(
  parameter int NMASTER    = 2,
  parameter bit MULTI      = 1'b1,
  parameter int HANG_CYC   = `HBR_HANG_CYC,
  parameter int TLOW_CYC   = `HBR_TLOW_CYC,
  parameter int THIGH_CYC  = `HBR_THIGH_CYC,
  parameter int TSTOP_CYC  = `HBR_TSTOP_CYC,
  parameter int NPULSE     = `HBR_PULSE_COUNT
) (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic [NMASTER-1:0] processor_reset_indication,
  input  wire logic               sda_in,
  input  wire logic               sck_in,
  output logic                    sda_out,
  output logic                    sda_oe_n,
  output logic                    sck_out,
  output logic                    sck_oe_n,
  output logic                    recovering,
  output logic                    hang_seen
);

  // ************************************************************
  // local widths
  // ************************************************************
  localparam int TW = $clog2(HANG_CYC + TLOW_CYC + THIGH_CYC + TSTOP_CYC + 2);
  localparam int PW = $clog2(NPULSE + 1);

  // cycle count cast to timer width; used by every timed phase
  function automatic logic [TW-1:0] cyc(input int n);
    cyc = TW'(n);
  endfunction

  // ************************************************************
  // design notes
  // ************************************************************
  // the block never drives a line high: every out bit is a constant
  // zero and only the enables move, so a wrong state can at worst
  // hold a line low, never fight a pull-up or another driver
  //
  // all bus decisions use the synchronised copies, which lag the wires
  // by two mclk edges; at 200 MHz that is far inside any bus phase,
  // so the lag only stretches the generated high phases a little
  //
  // the hang timer counts only while sck is seen high and still; a
  // slave stretching sck low is legal traffic and never ends a wait
  //
  // limitation: a slave that never lets go of sda keeps the nine-pulse
  // rounds going without end, even after the master reset is over
  //
  // trade-off: one down counter serves every timed phase, so the
  // watch timeout and the pulse phases can never overlap in time

  hbr_state_t        state_q;
  hbr_state_t        state_d;
  logic [TW-1:0]     timer_q;
  logic [PW-1:0]     pulses_q;
  logic [NMASTER-1:0] rst_sync;
  hbr_bus_t          bus;
  logic              any_reset;
  logic              sck_prev_q;
  logic              sck_edge;
  logic              timer_done;
  logic              sda_hold;
  hbr_od_t           sda_drv_q;
  hbr_od_t           sck_drv_q;
  logic              rec_q;
  logic              hang_q;

  // ************************************************************
  // input synchronisers
  // ************************************************************
  // reset indications
  hbr_sync #(.W(NMASTER)) u_rst_sync (
    .mclk     (mclk),
    .rst      (rst),
    .async_in (processor_reset_indication),
    .sync_out (rst_sync)
  );

  // fast bus sampling: mclk runs far above any bus clock
  hbr_sync #(.W(2)) u_bus_sync (
    .mclk     (mclk),
    .rst      (rst),
    .async_in ({sda_in, sck_in}),
    .sync_out (bus)
  );

  assign any_reset  = MULTI ? (|rst_sync) : rst_sync[0];
  assign timer_done = (timer_q == '0);

  // sck edge seen on the synchronised copy only
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sck_prev_q <= 1'b1;
    end else begin
      sck_prev_q <= bus.sck;
    end
  end
  assign sck_edge = (sck_prev_q != bus.sck);

  // ************************************************************
  // state machine
  // ************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      HBR_IDLE: begin
        if (any_reset) begin
          state_d = HBR_WATCH;
        end
      end
      HBR_WATCH: begin
        if (!any_reset) begin
          state_d = HBR_IDLE;
        end else if (bus.sda) begin
          state_d = HBR_WATCH;
        end else if (!MULTI) begin
          state_d = HBR_LOW;
        end else if (timer_done && bus.sck && !sck_edge) begin
          // sck stalled high too long; a late edge still counts as traffic
          state_d = HBR_LOW;
        end
      end
      HBR_LOW: begin
        if (timer_done) begin
          state_d = HBR_HIGH;
        end
      end
      HBR_HIGH: begin
        // high phase wait, stretched while sck held low
        if (timer_done && bus.sck) begin
          state_d = (pulses_q == PW'(NPULSE)) ? HBR_CHECK : HBR_LOW;
        end
      end
      HBR_CHECK: begin
        if (timer_done) begin
          if (!bus.sda) begin
            state_d = HBR_LOW;
          end else begin
            state_d = MULTI ? HBR_STOPLO : HBR_DONE;
          end
        end
      end
      HBR_STOPLO: begin
        if (timer_done) begin
          state_d = HBR_STOPHI;
        end
      end
      HBR_STOPHI: begin
        if (timer_done) begin
          state_d = HBR_DONE;
        end
      end
      HBR_DONE: begin
        // wait for reset to end before arming again
        if (!any_reset) begin
          state_d = HBR_IDLE;
        end
      end
      default: begin
        state_d = HBR_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= HBR_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ************************************************************
  // phase timer
  // ************************************************************
  // one down counter serves watch timeout and every drive phase
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      timer_q <= '0;
    end else if (state_q == HBR_WATCH && state_d == HBR_WATCH && (bus.sda || sck_edge || !bus.sck)) begin
      // the state check keeps a declared hang from loading the watch time into the low phase
      // toggling sck or low sck restarts the hang timer
      // timeout of four longest high times
      timer_q <= cyc(HANG_CYC);
    end else if (state_d != state_q) begin
      case (state_d)
        HBR_WATCH:  timer_q <= cyc(HANG_CYC);
        HBR_LOW:    timer_q <= cyc(TLOW_CYC);
        HBR_HIGH:   timer_q <= cyc(THIGH_CYC);
        HBR_CHECK:  timer_q <= cyc(TLOW_CYC);
        HBR_STOPLO: timer_q <= cyc(TLOW_CYC);
        HBR_STOPHI: timer_q <= cyc(TSTOP_CYC);
        default:    timer_q <= '0;
      endcase
    end else if (!timer_done && !(state_q == HBR_HIGH && !bus.sck)) begin
      timer_q <= timer_q - cyc(1);
    end
  end

  // ************************************************************
  // pulse counter
  // ************************************************************
  // nine pulses counted per round
  // cleared in watch and check so a repeated round counts nine afresh
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pulses_q <= '0;
    end else if (state_q == HBR_WATCH || state_q == HBR_CHECK) begin
      pulses_q <= '0;
    end else if (state_q == HBR_LOW && state_d == HBR_HIGH) begin
      pulses_q <= pulses_q + PW'(1);
    end
  end

  // ************************************************************
  // open-drain drivers
  // ************************************************************
  // sda is pulled one edge after sck goes low, so its fall never meets a
  // high sck (that would read as a start); it stays low across the edge
  // that releases sck and through the first half of the stop setup
  assign sda_hold = (state_q == HBR_STOPLO) ||
                    (state_q == HBR_STOPHI && state_d == HBR_STOPHI && timer_q > cyc(TSTOP_CYC / 2));

  // out is held low; only the enable moves
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sck_drv_q <= '{out: 1'b0, oe_n: 1'b1};
      sda_drv_q <= '{out: 1'b0, oe_n: 1'b1};
    end else begin
      // sck low phase pulled, released after last pulse
      sck_drv_q.out  <= 1'b0;
      sck_drv_q.oe_n <= !(state_d == HBR_LOW || state_d == HBR_STOPLO);
      // sda pulled low through the stop low phase and the first half of the stop setup, then
      // released while sck high to make the stop
      sda_drv_q.out  <= 1'b0;
      sda_drv_q.oe_n <= !sda_hold;
    end
  end

  // status flags
  // hang_seen is sticky so it can still be read once the master leaves
  // reset; only a fresh reset entry seen from idle clears it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rec_q  <= 1'b0;
      hang_q <= 1'b0;
    end else begin
      rec_q <= !(state_d == HBR_IDLE || state_d == HBR_WATCH || state_d == HBR_DONE);
      if (state_q == HBR_WATCH && state_d == HBR_LOW) begin
        hang_q <= 1'b1;
      end else if (state_q == HBR_IDLE && any_reset) begin
        hang_q <= 1'b0;
      end
    end
  end

  assign sck_out    = sck_drv_q.out;
  assign sck_oe_n   = sck_drv_q.oe_n;
  assign sda_out    = sda_drv_q.out;
  assign sda_oe_n   = sda_drv_q.oe_n;
  assign recovering = rec_q;
  assign hang_seen  = hang_q;

endmodule

// file: verilog/hbr_params.svh
// timing and sizing constants for the bus-hang recovery block
// assumes a 200 MHz sampling clock (mclk)
`ifndef HBR_PARAMS_SVH
`define HBR_PARAMS_SVH

// ************************************************************
// clock and bus timing
// ************************************************************
`define HBR_MCLK_PERIOD_PS   5000
`define HBR_TLOW_MIN_NS      4700
`define HBR_THIGH_MIN_NS     4000
`define HBR_SCK_HIGH_MAX_NS  5000
`define HBR_HANG_FACTOR      4
`define HBR_TSU_STOP_NS      4000
`define HBR_PULSE_COUNT      9

// derived cycle counts: least times round up
`define HBR_TLOW_CYC  ((`HBR_TLOW_MIN_NS * 1000 + `HBR_MCLK_PERIOD_PS - 1) / `HBR_MCLK_PERIOD_PS)
`define HBR_THIGH_CYC ((`HBR_THIGH_MIN_NS * 1000 + `HBR_MCLK_PERIOD_PS - 1) / `HBR_MCLK_PERIOD_PS)
`define HBR_TSTOP_CYC ((`HBR_TSU_STOP_NS * 1000 + `HBR_MCLK_PERIOD_PS - 1) / `HBR_MCLK_PERIOD_PS)
`define HBR_HANG_CYC  ((`HBR_HANG_FACTOR * `HBR_SCK_HIGH_MAX_NS * 1000) / `HBR_MCLK_PERIOD_PS)

`endif

// file: verilog/hbr_pkg.sv
// types for the bus-hang recovery block
// assumes hbr_params.svh supplies the numeric constants
package hbr_pkg;

  // ************************************************************
  // state machine
  // ************************************************************
  typedef enum logic [7:0] {
    HBR_IDLE   = 8'b0000_0001,
    HBR_WATCH  = 8'b0000_0010,
    HBR_LOW    = 8'b0000_0100,
    HBR_HIGH   = 8'b0000_1000,
    HBR_CHECK  = 8'b0001_0000,
    HBR_STOPLO = 8'b0010_0000,
    HBR_STOPHI = 8'b0100_0000,
    HBR_DONE   = 8'b1000_0000
  } hbr_state_t;

  // driven side of one open-drain pin, split into two signals
  typedef struct packed {
    logic out;
    logic oe_n;
  } hbr_od_t;

  // synchronised view of the bus wires
  typedef struct packed {
    logic sda;
    logic sck;
  } hbr_bus_t;

endpackage

// file: verilog/hbr_sync.sv
// two-flop synchroniser for pins arriving from outside mclk
// assumes the inputs are asynchronous levels
`timescale 1ns/1ps
module hbr_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second; idle level of the wires is high
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_q   <= '1;
      sync_out <= '1;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// file: verif/hbr_recovery_sva.sv
// checker for the bus-hang recovery block, bound to hbr_recovery
// assumes sda_in and sck_in carry the resolved wire levels
`timescale 1ns/1ps
module hbr_recovery_sva #(
  parameter int NMASTER   = 2,
  parameter int HANG_CYC  = 40,
  parameter int TLOW_CYC  = 6,
  parameter int THIGH_CYC = 5
) (
  input wire logic               mclk,
  input wire logic               rst,
  input wire logic [NMASTER-1:0] processor_reset_indication,
  input wire logic               sda_in,
  input wire logic               sck_in,
  input wire logic               sda_out,
  input wire logic               sda_oe_n,
  input wire logic               sck_out,
  input wire logic               sck_oe_n,
  input wire logic               recovering,
  input wire logic               hang_seen
);
  int lo_cnt;
  int hi_cnt;
  int stall;
  // ************************************************************
  // phase and stall counters
  // ************************************************************
  // raw wires lead the synchronised view, so these counts run ahead of the design
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lo_cnt <= 0;
      hi_cnt <= 0;
      stall  <= 0;
    end else begin
      lo_cnt <= sck_oe_n ? 0 : lo_cnt + 1;
      hi_cnt <= (sck_oe_n && sck_in) ? hi_cnt + 1 : 0;
      stall  <= (|processor_reset_indication && !sda_in && sck_in) ? stall + 1 : 0;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_pull_sck; !sck_oe_n && recovering && sda_oe_n; endsequence
  sequence s_sda_rise; $rose(sda_oe_n); endsequence
  property p_low_only; !sda_out && !sck_out; endproperty
  a_low_only: assert property (p_low_only) else $error("pin driven high");
  property p_idle_free; !recovering |-> sda_oe_n && sck_oe_n; endproperty
  a_idle_free: assert property (p_idle_free) else $error("line held outside recovery");
  property p_low_phase; $rose(sck_oe_n) |-> lo_cnt >= TLOW_CYC; endproperty
  a_low_phase: assert property (p_low_phase) else $error("sck low phase short");
  property p_high_phase; $fell(sck_oe_n) && $past(recovering) |-> hi_cnt >= THIGH_CYC; endproperty
  a_high_phase: assert property (p_high_phase) else $error("sck high phase short");
  property p_stall_min; $rose(hang_seen) |-> stall >= HANG_CYC; endproperty
  a_stall_min: assert property (p_stall_min) else $error("hang declared early");
  property p_deadline; stall == HANG_CYC |-> ##[1:8] hang_seen; endproperty
  a_deadline: assert property (p_deadline) else $error("hang not declared");
  property p_cause; $rose(hang_seen) |-> $past(processor_reset_indication, 4) != 0; endproperty
  a_cause: assert property (p_cause) else $error("hang without master reset");
  property p_start; $rose(hang_seen) |-> ##[0:1] s_pull_sck; endproperty
  a_start: assert property (p_start) else $error("recovery did not start");
  property p_stop; s_sda_rise |-> sck_oe_n && sck_in; endproperty
  a_stop: assert property (p_stop) else $error("sda released with sck low");
endmodule
bind hbr_recovery hbr_recovery_sva #(.NMASTER(NMASTER), .HANG_CYC(HANG_CYC), .TLOW_CYC(TLOW_CYC),
  .THIGH_CYC(THIGH_CYC)) u_sva (.mclk(mclk), .rst(rst), .processor_reset_indication(processor_reset_indication),
  .sda_in(sda_in), .sck_in(sck_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .sck_out(sck_out),
  .sck_oe_n(sck_oe_n), .recovering(recovering), .hang_seen(hang_seen));

// file: verif/hbr_slave_model.sv
// slave memory stuck in a read, holding sda low for a set number of bits
// assumes sck is the resolved wire; sda_pull high means pulling sda low
`timescale 1ns/1ps
module hbr_slave_model (
  input  wire logic       sck,
  input  wire logic       arm,
  input  wire logic [7:0] arm_bits,
  output logic            sda_pull
);
  int   cnt   = 0;
  logic arm_q = 1'b0;
  // bits pending are loaded when arm rises
  // next bit after sck falls; held while sck high
  // one process owns the count, so it has a single driver
  always @(arm or negedge sck) begin
    if (arm !== arm_q) begin
      if (arm === 1'b1) cnt = arm_bits;
      arm_q = arm;
    end else if (cnt != 0) begin
      cnt = cnt - 1;
    end
  end
  assign sda_pull = (cnt != 0);
endmodule

// file: verif/test_hbr_recovery.sv
// self-checking bench for the bus-hang recovery block
// assumes open-drain wires with pull-ups resolved here, two masters
`timescale 1ns/1ps
module test_hbr_recovery;
  import hbr_pkg::*;
  localparam int HC = 40;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  rst_ind = 2'b00;
  logic        tb_sda_low = 1'b0;
  logic        tb_sck_low = 1'b0;
  logic        arm = 1'b0;
  logic [7:0]  bits = 8'h00;
  logic        sda_out, sda_oe_n, sck_out, sck_oe_n, recovering, hang_seen, slv_pull, pr, pk, pd;
  logic [7:0]  np = 8'h00;
  logic [7:0]  ns = 8'h00;
  logic [15:0] lfsr = 16'h886E;
  logic [15:0] expq[$];
  int          num_errors = 0;
  int          comparisons = 0;
  wire         sda = (sda_oe_n | sda_out) & ~slv_pull & ~tb_sda_low;
  wire         sck = (sck_oe_n | sck_out) & ~tb_sck_low;
  initial forever #2.5 mclk = ~mclk;
  hbr_recovery #(.NMASTER(2), .MULTI(1'b1), .HANG_CYC(HC), .TLOW_CYC(6), .THIGH_CYC(5), .TSTOP_CYC(6)) dut_u (
    .mclk(mclk), .rst(rst), .processor_reset_indication(rst_ind), .sda_in(sda), .sck_in(sck),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
    .recovering(recovering), .hang_seen(hang_seen));
  hbr_slave_model slv_u (.sck(sck), .arm(arm), .arm_bits(bits), .sda_pull(slv_pull));
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge mclk);
  endtask
  function automatic void step;
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
  endfunction
  // stuck slave with k bits left; rounds of nine until it lets go, then one stop
  task automatic hang_case(input logic [7:0] k);
    int i;
    expq.push_back({8'((k + 8) / 9 * 9 + 1), 8'h01});
    bits = k;
    arm = 1'b1;
    cycles(4);
    step();
    rst_ind = (lfsr[1:0] == 2'b00) ? 2'b01 : lfsr[1:0];
    cycles(HC);
    i = 0;
    while (!(hang_seen === 1'b1 && recovering === 1'b0) && i < 4000) begin
      cycles(1);
      i++;
    end
    // a hang here counts once; the run still ends in the closing report
    if (i == 4000) begin
      num_errors++;
    end
    check({14'h0000, sda, hang_seen}, 16'h0003);
    rst_ind = 2'b00;
    arm = 1'b0;
    cycles(10);
  endtask
  // ************************************************************
  // result monitor: pulses and stops of each recovery, oldest note first
  // ************************************************************
  // sampled on the falling edge, well clear of the edge that launches the outputs
  always @(negedge mclk) begin
    pr <= recovering;
    pk <= sck;
    pd <= sda;
    if (recovering === 1'b1) begin
      if (pk && !sck) np <= np + 8'h01;
      if (!pd && sda && sck) ns <= ns + 8'h01;
    end else begin
      if (pr === 1'b1 && expq.size() == 0) check({np, ns}, 16'hFFFF);
      else if (pr === 1'b1) check({np, ns}, expq.pop_front());
      np <= 8'h00;
      ns <= 8'h00;
    end
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    cycles(2);
    rst = 1'b0;
    rst_ind = 2'b01;
    cycles(3 * HC);
    check({12'h000, hang_seen, recovering, sda_oe_n, sck_oe_n}, 16'h0003);
    rst_ind = 2'b00;
    cycles(5);
    // other master clocking, link period 48 ns, phase unrelated to mclk
    rst_ind = 2'b10;
    tb_sda_low = (sda === 1'b1); // start only on a free bus
    repeat (40) #24 tb_sck_low = ~tb_sck_low;
    tb_sda_low = 1'b0;
    cycles(1);
    check({14'h0000, hang_seen, recovering}, 16'h0000);
    rst_ind = 2'b00;
    cycles(5);
    step();
    hang_case(8'(lfsr[2:0]) + 8'h01);
    step();
    hang_case(8'h0A + 8'(lfsr[2:0]));
    check(16'(expq.size()), 16'h0000);
    give_verdict();
  end
endmodule
